// [hw/sync_serial_pkg.sv]
// Constants, register map and carrier types of the synchronous serial channel
package sync_serial_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ----------------------------------------------------------------
  localparam int        ADR_W     = 5;
  localparam logic [4:0] OFS_CTRL  = 5'h00;
  localparam logic [4:0] OFS_BAUD  = 5'h04;
  localparam logic [4:0] OFS_TXBUF = 5'h08;
  localparam logic [4:0] OFS_RXBUF = 5'h0c;
  localparam logic [4:0] OFS_STAT  = 5'h10;
  localparam logic [4:0] OFS_CLR   = 5'h14;
  localparam logic [4:0] OFS_IEN   = 5'h18;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int          DATA_W    = 16;
  localparam int          LEN_W     = 4;
  localparam int          BAUD_W    = 16;
  localparam int          ECNT_W    = 5;
  localparam int          GAP_W     = 18;
  localparam logic [3:0]  LEN_MIN_M1 = 4'h1;
  localparam logic [15:0] BAUD_RST  = 16'h0000;
  localparam logic [15:0] ONES16    = 16'hffff;
  localparam int          STAT_BUSY = 8;
  localparam int          STAT_TXF  = 9;
  localparam int          STAT_RXF  = 10;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic             pin_swap;   // Bit 11: swap data pin roles
    logic             half;       // Bit 10: half duplex
    logic             loopback;   // Bit 9
    logic             enable;     // Bit 8
    logic             master;     // Bit 7
    logic             cpha;       // Bit 6
    logic             cpol;       // Bit 5
    logic             msb_first;  // Bit 4
    logic [LEN_W-1:0] len_m1;     // Bits 3:0: bits per character - 1
  } ctrl_s;
  localparam int    CTRL_W   = 12;
  localparam ctrl_s CTRL_RST = '0;

  typedef struct packed {
    logic baud_err;
    logic phase_err;
    logic rx_err;
    logic tx_err;
    logic rx_full;
    logic tx_empty;
  } evt_s;
  localparam int EVT_W = 6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } eng_e;
endpackage : sync_serial_pkg

// [hw/sync2.sv]
// Two-flop synchroniser for one pin input
`timescale 1ns/10ps
`default_nettype none
module sync2 (
  input  wire logic clk,   // System clock
  input  wire logic rstn,  // Async reset, active low
  input  wire logic d,     // Asynchronous input
  output logic      q      // Synchronised level
);
  logic meta_q;

  // First flop is read only by the second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

// [hw/sync_serial_channel.sv]
// Synchronous serial channel with Wishbone register slave
`timescale 1ns/10ps
`default_nettype none
module sync_serial_channel
  import sync_serial_pkg::*;
(
  input  wire logic              clk,       // System clock, 100 MHz
  input  wire logic              rstn,      // Async reset, active low
  input  wire logic              wb_cyc_i,  // Bus cycle
  input  wire logic              wb_stb_i,  // Strobe
  input  wire logic              wb_we_i,   // Write enable
  input  wire logic [ADR_W-1:0]  wb_adr_i,  // Byte address
  input  wire logic [3:0]        wb_sel_i,  // Byte enables
  input  wire logic [31:0]       wb_dat_i,  // Write data
  output logic      [31:0]       wb_dat_o,  // Read data
  output logic                   wb_ack_o,  // Acknowledge
  input  wire logic              sclk_i,    // Clock pin in
  output logic                   sclk_o,    // Clock pin out
  output logic                   sclk_oe,   // Clock pin drive
  input  wire logic              dat_a_i,   // Data pin a in
  output logic                   dat_a_o,   // Data pin a out
  output logic                   dat_a_oe,  // Data pin a drive
  input  wire logic              dat_b_i,   // Data pin b in
  output logic                   dat_b_o,   // Data pin b out
  output logic                   dat_b_oe,  // Data pin b drive
  output logic                   irq_tx,    // Transmit interrupt
  output logic                   irq_rx,    // Receive interrupt
  output logic                   irq_err,   // Error interrupt
  output logic                   irq        // Any enabled event
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic sclk_s, dat_a_s, dat_b_s;

  sync2 u_sync_sclk (.clk(clk), .rstn(rstn), .d(sclk_i),  .q(sclk_s));
  sync2 u_sync_a    (.clk(clk), .rstn(rstn), .d(dat_a_i), .q(dat_a_s));
  sync2 u_sync_b    (.clk(clk), .rstn(rstn), .d(dat_b_i), .q(dat_b_s));

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ctrl_s              ctrl_q, ctrl_d;
  logic [BAUD_W-1:0]  baud_q, baud_d;
  logic [DATA_W-1:0]  txbuf_q, txbuf_d;
  logic [DATA_W-1:0]  rxbuf_q, rxbuf_d;
  logic [DATA_W-1:0]  txs_q, txs_d;
  logic [DATA_W-1:0]  rxs_q, rxs_d;
  logic               txf_q, txf_d;
  logic               rxf_q, rxf_d;
  evt_s               evt_q, evt_d;
  evt_s               ien_q, ien_d;
  eng_e               st_q, st_d;
  logic [ECNT_W-1:0]  ecnt_q, ecnt_d;
  logic [BAUD_W-1:0]  bcnt_q, bcnt_d;
  logic [GAP_W-1:0]   gap_q, gap_d;
  logic               sclk_q, sclk_d;
  logic               sprev_q, din_prev_q;
  logic               ack_q, ack_d;
  logic [31:0]        rdat_q, rdat_d;

  // ----------------------------------------------------------------
  // Derived signals
  // ----------------------------------------------------------------
  logic [LEN_W-1:0]   len_m1;
  logic               out_bit, din_pin, din, sedge, busy;
  logic               req, wr_go, rd_go;
  logic [31:0]        wmask, wval;
  logic [GAP_W-1:0]   gap_max;

  // Length below two bits is raised to two
  assign len_m1  = (ctrl_q.len_m1 < LEN_MIN_M1) ? LEN_MIN_M1 : ctrl_q.len_m1;
  assign out_bit = ctrl_q.msb_first ? txs_q[len_m1] : txs_q[0];
  assign din_pin = ctrl_q.pin_swap ? dat_a_s : dat_b_s;
  assign din     = ctrl_q.loopback ? out_bit : din_pin;
  assign sedge   = sclk_s ^ sprev_q;                   // Slave clock edge seen
  assign busy    = (st_q != ST_IDLE);
  assign gap_max = {1'b0, baud_q, 1'b1} + {{(GAP_W-1){1'b0}}, 1'b1};

  // Bus decode
  assign req   = wb_cyc_i & wb_stb_i;
  assign wr_go = req & wb_we_i & ack_q;
  assign rd_go = req & ~wb_we_i & ack_q;
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // ----------------------------------------------------------------
  // Pins and interrupts
  // ----------------------------------------------------------------
  // Clock pin is driven only by a master
  assign sclk_o   = sclk_q;
  assign sclk_oe  = ctrl_q.enable & ctrl_q.master;
  // Half duplex releases the data line between frames to share it
  assign dat_a_o  = out_bit;
  assign dat_b_o  = out_bit;
  assign dat_a_oe = ctrl_q.enable & ~ctrl_q.pin_swap & (~ctrl_q.half | busy);
  assign dat_b_oe = ctrl_q.enable & ctrl_q.pin_swap & (~ctrl_q.half | busy);
  assign irq_tx   = evt_q.tx_empty & ien_q.tx_empty;
  assign irq_rx   = evt_q.rx_full & ien_q.rx_full;
  assign irq_err  = |({evt_q.baud_err, evt_q.phase_err, evt_q.rx_err, evt_q.tx_err}
                      & {ien_q.baud_err, ien_q.phase_err, ien_q.rx_err, ien_q.tx_err});
  assign irq      = |(evt_q & ien_q);
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ----------------------------------------------------------------
  // Bus answer: one wait state, data registered with ack
  // ----------------------------------------------------------------
  always_comb begin
    ack_d  = req & ~ack_q;
    rdat_d = rdat_q;
    if (req & ~ack_q) begin
      rdat_d = 32'h0000_0000;    // Unmapped reads return zero
      case (wb_adr_i)
        OFS_CTRL:  rdat_d[CTRL_W-1:0] = ctrl_q;
        OFS_BAUD:  rdat_d[BAUD_W-1:0] = baud_q;
        OFS_TXBUF: rdat_d[DATA_W-1:0] = txbuf_q;
        OFS_RXBUF: rdat_d[DATA_W-1:0] = rxbuf_q;
        OFS_STAT: begin
          rdat_d[EVT_W-1:0] = evt_q;
          rdat_d[STAT_BUSY] = busy;
          rdat_d[STAT_TXF]  = txf_q;
          rdat_d[STAT_RXF]  = rxf_q;
        end
        OFS_IEN:   rdat_d[EVT_W-1:0] = ien_q;
        default:   rdat_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ----------------------------------------------------------------
  // Registers, buffers and shift engine
  // ----------------------------------------------------------------
  always_comb begin
    logic edge_ev, lead, smp, clr_set, tx_wr;
    logic [EVT_W-1:0] clr;
    evt_s set;
    edge_ev = 1'b0;
    tx_wr   = 1'b0;
    lead    = 1'b0;
    smp     = 1'b0;
    clr_set = 1'b0;
    clr     = '0;
    set     = '0;
    wval    = (32'h0000_0000 & ~wmask) | (wb_dat_i & wmask);
    ctrl_d  = ctrl_q;
    baud_d  = baud_q;
    txbuf_d = txbuf_q;
    rxbuf_d = rxbuf_q;
    txs_d   = txs_q;
    rxs_d   = rxs_q;
    txf_d   = txf_q;
    rxf_d   = rxf_q;
    ien_d   = ien_q;
    st_d    = st_q;
    ecnt_d  = ecnt_q;
    bcnt_d  = bcnt_q;
    gap_d   = gap_q;
    sclk_d  = sclk_q;

    // Software writes with byte enables
    if (wr_go) begin
      case (wb_adr_i)
        OFS_CTRL: ctrl_d = ctrl_s'(({20'h00000, ctrl_q} & ~wmask) | wval);
        OFS_BAUD: baud_d = BAUD_W'(({16'h0000, baud_q} & ~wmask) | wval);
        OFS_TXBUF: begin
          txbuf_d = DATA_W'(({16'h0000, txbuf_q} & ~wmask) | wval);
          set.tx_err = txf_q;    // Overwrites an unsent character
          txf_d      = 1'b1;
          tx_wr      = 1'b1;
        end
        OFS_CLR: begin
          clr_set = 1'b1;
          clr     = wb_dat_i[EVT_W-1:0] & wmask[EVT_W-1:0];
        end
        OFS_IEN:  ien_d = evt_s'(({26'h0000000, ien_q} & ~wmask) | wval);
        default: ;
      endcase
    end
    if (rd_go && (wb_adr_i == OFS_RXBUF)) begin
      rxf_d = 1'b0;              // Reading the receive buffer frees it
    end

    // Idle slave shows the waiting character so its first bit is ready
    if ((st_q == ST_IDLE) && txf_q && !ctrl_q.master) begin
      txs_d = txbuf_q;
    end

    // Baud divider, counted in half bit periods
    if (busy && ctrl_q.master) begin
      if (bcnt_q == '0) begin
        bcnt_d  = baud_q;
        edge_ev = (st_q == ST_RUN);
      end else begin
        bcnt_d = bcnt_q - 1'b1;
      end
    end

    // Frame start, slave clock rate checks and frame end
    case (st_q)
      ST_IDLE: begin
        ecnt_d = '0;
        sclk_d = ctrl_q.cpol;    // Clock rests at idle level
        if (ctrl_q.enable && ctrl_q.master && txf_q) begin
          txs_d          = txbuf_q;
          txf_d          = tx_wr; // A write in the start cycle is kept, not lost
          set.tx_empty   = 1'b1;
          bcnt_d         = baud_q;
          st_d           = ST_RUN;
        end else if (ctrl_q.enable && !ctrl_q.master && sedge) begin
          edge_ev = 1'b1;        // Slave frame starts on first edge
          st_d    = ST_RUN;
          gap_d   = '0;
          if (txf_q) begin
            txs_d        = txbuf_q;
            txf_d        = tx_wr;
            set.tx_empty = 1'b1;
          end else begin
            set.tx_err   = 1'b1; // Nothing new to send
          end
        end
      end
      ST_RUN: begin
        if (!ctrl_q.master) begin
          edge_ev = sedge;
          gap_d   = sedge ? '0 : gap_q + 1'b1;
          // Clock slower than half the programmed rate
          if (gap_q == gap_max) begin
            set.baud_err = 1'b1;
          end
          // Clock faster than twice the programmed rate
          if (sedge && (gap_q < GAP_W'(baud_q >> 1))) begin
            set.baud_err = 1'b1;
          end
        end
      end
      ST_DONE: begin
        st_d    = ST_IDLE;
        if (!ctrl_q.msb_first) begin
          rxbuf_d = (rxs_q >> (4'hf - len_m1)) & (ONES16 >> (4'hf - len_m1));
        end else begin
          rxbuf_d = rxs_q & (ONES16 >> (4'hf - len_m1));
        end
        set.rx_err  = rxf_q;     // Previous character never read
        set.rx_full = 1'b1;
        rxf_d       = 1'b1;
      end
      default: st_d = ST_IDLE;
    endcase

    // One clock edge: sample on one, shift on the other
    if (edge_ev) begin
      lead   = ~ecnt_q[0];
      smp    = lead ^ ctrl_q.cpha;
      sclk_d = ~sclk_q;
      ecnt_d = ecnt_q + 1'b1;
      if (smp) begin
        rxs_d = ctrl_q.msb_first ? {rxs_q[DATA_W-2:0], din}
                                 : {din, rxs_q[DATA_W-1:1]};
        // Data moving at the latch edge is unreliable
        if (!ctrl_q.master && !ctrl_q.loopback && (din_pin != din_prev_q)) begin
          set.phase_err = 1'b1;
        end
      end else if (ecnt_q != '0) begin
        txs_d = ctrl_q.msb_first ? {txs_q[DATA_W-2:0], 1'b0}
                                 : {1'b0, txs_q[DATA_W-1:1]};
      end
      if (ecnt_q == {len_m1, 1'b1}) begin
        st_d   = ST_DONE;        // Last edge of the character
        sclk_d = ctrl_q.cpol;
      end
    end

    // Disabling the channel aborts any frame
    if (!ctrl_q.enable) begin
      st_d   = ST_IDLE;
      sclk_d = ctrl_q.cpol;
    end

    // Hardware set wins over software clear
    evt_d = evt_s'((evt_q & ~(clr_set ? clr : '0)) | set);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q     <= CTRL_RST;
      baud_q     <= BAUD_RST;
      txbuf_q    <= '0;
      rxbuf_q    <= '0;
      txs_q      <= '0;
      rxs_q      <= '0;
      txf_q      <= 1'b0;
      rxf_q      <= 1'b0;
      evt_q      <= '0;
      ien_q      <= '0;
      st_q       <= ST_IDLE;
      ecnt_q     <= '0;
      bcnt_q     <= '0;
      gap_q      <= '0;
      sclk_q     <= 1'b0;
      sprev_q    <= 1'b0;
      din_prev_q <= 1'b0;
    end else begin
      ctrl_q     <= ctrl_d;
      baud_q     <= baud_d;
      txbuf_q    <= txbuf_d;
      rxbuf_q    <= rxbuf_d;
      txs_q      <= txs_d;
      rxs_q      <= rxs_d;
      txf_q      <= txf_d;
      rxf_q      <= rxf_d;
      evt_q      <= evt_d;
      ien_q      <= ien_d;
      st_q       <= st_d;
      ecnt_q     <= ecnt_d;
      bcnt_q     <= bcnt_d;
      gap_q      <= gap_d;
      sclk_q     <= sclk_d;
      sprev_q    <= sclk_s;
      din_prev_q <= din_pin;
    end
  end
endmodule : sync_serial_channel
`default_nettype wire

// [test/sync_serial_channel_properties.sv]
// Port-level properties of the synchronous serial channel
`timescale 1ns/10ps
`default_nettype none
module sync_serial_channel_properties
  import sync_serial_pkg::*;
(
  input wire logic             clk,       // System clock
  input wire logic             rstn,      // Async reset, active low
  input wire logic             wb_cyc_i,  // Bus cycle
  input wire logic             wb_stb_i,  // Strobe
  input wire logic             wb_we_i,   // Write enable
  input wire logic [ADR_W-1:0] wb_adr_i,  // Byte address
  input wire logic [3:0]       wb_sel_i,  // Byte enables
  input wire logic [31:0]      wb_dat_i,  // Write data
  input wire logic [31:0]      wb_dat_o,  // Read data
  input wire logic             wb_ack_o,  // Acknowledge
  input wire logic             sclk_oe,   // Clock pin drive
  input wire logic             dat_a_o,   // Data pin a out
  input wire logic             dat_a_oe,  // Data pin a drive
  input wire logic             dat_b_o,   // Data pin b out
  input wire logic             dat_b_oe,  // Data pin b drive
  input wire logic             irq_tx,    // Transmit interrupt
  input wire logic             irq_rx,    // Receive interrupt
  input wire logic             irq_err,   // Error interrupt
  input wire logic             irq        // Any enabled event
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  // Completed write, the only cause for a mode change
  wire wr_acc = wb_ack_o && wb_we_i;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  chk_ack_latency: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_unmapped_zero: assert property (
    wb_ack_o && !wb_we_i && (wb_adr_i == 5'h1c || wb_adr_i == OFS_CLR)
    |-> wb_dat_o == 32'h0)
    else $error("unmapped or write-only read not zero");

  // ----------------------------------------------------------------
  // Interrupts and pins
  // ----------------------------------------------------------------
  chk_irq_any: assert property (
    irq == (irq_tx | irq_rx | irq_err))
    else $error("summary irq differs from sources");
  chk_clr_irq: assert property (
    wr_acc && wb_adr_i == OFS_CLR && wb_sel_i[0] && wb_dat_i[5:0] == 6'h3f
    |-> ##[1:2] !irq)
    else $error("irq stays after full clear");
  chk_oe_excl: assert property (
    dat_a_oe |-> !dat_b_oe)
    else $error("both data pins driven");
  chk_dat_same: assert property (
    dat_a_o == dat_b_o)
    else $error("data pins carry different bits");
  chk_oe_after_wr: assert property (
    $changed(sclk_oe) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("clock drive changed without a write");
endmodule : sync_serial_channel_properties

bind sync_serial_channel sync_serial_channel_properties i_sync_serial_channel_properties (
  .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .sclk_oe, .dat_a_o, .dat_a_oe, .dat_b_o, .dat_b_oe,
  .irq_tx, .irq_rx, .irq_err, .irq);
`default_nettype wire

// [test/link_peer.sv]
// Behavioural far-side master for slave-mode transfers
`timescale 1ns/10ps
`default_nettype none
module link_peer (
  input  wire logic        go,    // Frame request
  input  wire logic [15:0] tx,    // Word to send
  input  wire logic        miso,  // Data from channel
  output logic             sclk,  // Link clock, 125 ns period
  output logic             mosi,  // Data to channel
  output logic      [15:0] rx     // Word received
);
  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // Clock stands low outside frames
  // MSB first, shift on leading edge, latch on trailing
  initial begin
    sclk = 1'b0;
    mosi = 1'b0;
    rx   = '0;
    forever begin
      @(posedge go);
      #3.3;  // Phase unrelated to the system clock
      for (int i = 15; i >= 0; i--) begin
        sclk = 1'b1;
        mosi = tx[i];
        #62.5;
        sclk = 1'b0;
        rx   = {rx[14:0], miso};
        #62.5;
      end
      mosi = ~mosi;  // Released line must not look held
    end
  end
endmodule : link_peer
`default_nettype wire

// [test/tb_sync_serial_channel.sv]
// Self-checking bench for the synchronous serial channel
`timescale 1ns/10ps
`default_nettype none
module tb_sync_serial_channel
  import sync_serial_pkg::*;
;
  logic             clk = 1'b0, rstn = 1'b0, go = 1'b0;
  logic             wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0]       wb_sel_i = '0;
  logic [31:0]      wb_dat_i = '0, wb_dat_o, q;
  logic             wb_ack_o, sclk_o, sclk_oe, dat_a_o, dat_a_oe, dat_b_o, dat_b_oe;
  logic             irq_tx, irq_rx, irq_err, irq, p_sclk, p_mosi;
  logic [15:0]      p_tx = '0, p_rx;
  int               fails = 0, n_checks = 0;

  // Pin levels from all drivers; released pin a shows the inverse of dat_a_o, released clock and b pins follow the peer
  wire pin_c = sclk_oe ? sclk_o : p_sclk;
  wire pin_a = dat_a_oe ? dat_a_o : ~dat_a_o;
  wire pin_b = dat_b_oe ? dat_b_o : p_mosi;

  always #5 clk = ~clk;

  sync_serial_channel i_sync_serial_channel (
    .clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .sclk_i(pin_c), .sclk_o, .sclk_oe,
    .dat_a_i(pin_a), .dat_a_o, .dat_a_oe, .dat_b_i(pin_b), .dat_b_o,
    .dat_b_oe, .irq_tx, .irq_rx, .irq_err, .irq);
  link_peer i_link_peer (.go, .tx(p_tx), .miso(pin_a), .sclk(p_sclk),
    .mosi(p_mosi), .rx(p_rx));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  // Classic single cycle; held until ack, released for one cycle after
  task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) begin
      fails++;
      end_of_test();
    end
    @(posedge clk);
  endtask : bus

  task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask : rd

  // Bounded wait for the receive interrupt
  task automatic wait_rx();
    for (int n = 0; n < 3000 && irq_rx !== 1'b1; n++) @(posedge clk);
    if (irq_rx !== 1'b1) begin
      fails++;
      end_of_test();
    end
  endtask : wait_rx

  // One master loop-back character in a given mode
  task automatic xfer(input logic [11:0] c, input logic [15:0] d);
    logic [15:0] m;
    m = 16'hffff >> (4'hf - c[3:0]);
    bus(1'b1, OFS_CTRL, {20'h0, c});
    @(posedge clk);  // Idle clock level is registered one cycle after the write
    chk("sclk_idle", {31'h0, sclk_o}, {31'h0, c[5]});
    chk("sclk_oe", {31'h0, sclk_oe}, 32'h1);
    chk("oe_a", {31'h0, dat_a_oe}, {31'h0, !c[11] && !c[10]});
    chk("oe_b", {31'h0, dat_b_oe}, {31'h0, c[11] && !c[10]});
    bus(1'b1, OFS_TXBUF, {16'h0, d});
    wait_rx();
    rd(OFS_RXBUF, {16'h0, d & m}, "rxbuf");
    rd(OFS_STAT, 32'h3, "stat");
    chk("irq_tx", {31'h0, irq_tx}, 32'h1);
    bus(1'b1, OFS_CLR, 32'h3f);
    chk("irq_clr", {31'h0, irq}, 32'h0);
  endtask : xfer

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int   n;
    logic s;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFS_CTRL, 32'h0, "ctrl_rst");
    rd(OFS_BAUD, 32'h0, "baud_rst");
    bus(1'b1, 5'h1c, 32'hffff);
    rd(5'h1c, 32'h0, "unmapped");
    bus(1'b1, OFS_IEN, 32'h3f);
    xfer(12'h381, 16'h0002);
    xfer(12'h3ff, 16'ha5c3);
    xfer(12'h3a7, 16'h005a);
    xfer(12'hfcb, 16'h0abc);
    // Divider and an unread character overwritten
    bus(1'b1, OFS_CTRL, 32'h39f);
    bus(1'b1, OFS_BAUD, 32'h3);
    s = sclk_o;
    bus(1'b1, OFS_TXBUF, 32'h1234);
    for (n = 0; n < 100 && sclk_o === s; n++) @(posedge clk);
    for (n = 0; n < 100 && sclk_o !== s; n++) @(posedge clk);
    chk("half_bit", n, 32'd4);
    wait_rx();
    bus(1'b1, OFS_CLR, 32'h3f);
    bus(1'b1, OFS_TXBUF, 32'h5678);
    wait_rx();
    rd(OFS_STAT, 32'h40b, "overrun");
    chk("irq_err", {31'h0, irq_err}, 32'h1);
    bus(1'b1, OFS_IEN, 32'h0);
    chk("masked", {31'h0, irq}, 32'h0);
    rd(OFS_RXBUF, 32'h5678, "rx_last");
    bus(1'b1, OFS_CLR, 32'h3f);
    bus(1'b1, OFS_IEN, 32'h3f);
    // Buffer overwrite while the channel is off
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_TXBUF, 32'h1111);
    bus(1'b1, OFS_TXBUF, 32'h2222);
    rd(OFS_STAT, 32'h204, "tx_err");
    // Slave frames clocked by the far side
    bus(1'b1, OFS_BAUD, 32'h4);
    bus(1'b1, OFS_CTRL, 32'h15f);
    bus(1'b1, OFS_TXBUF, 32'h3c96);
    bus(1'b1, OFS_CLR, 32'h3f);
    chk("slave_oe", {31'h0, sclk_oe}, 32'h0);
    p_tx <= 16'hb17e;
    go   <= 1'b1;
    wait_rx();
    go   <= 1'b0;
    rd(OFS_RXBUF, 32'hb17e, "slave_rx");
    chk("peer_rx", {16'h0, p_rx}, 32'h3c96);
    bus(1'b1, OFS_CLR, 32'h3f);
    go <= 1'b1;
    wait_rx();
    go <= 1'b0;
    bus(1'b0, OFS_STAT, 32'h0);
    chk("slave_empty", q & 32'h4, 32'h4);
    // Wrong phase and a clock far faster than the programmed rate
    bus(1'b1, OFS_BAUD, 32'h14);
    bus(1'b1, OFS_CTRL, 32'h11f);
    bus(1'b1, OFS_CLR, 32'h3f);
    go <= 1'b1;
    wait_rx();
    go <= 1'b0;
    bus(1'b0, OFS_STAT, 32'h0);
    chk("phase_err", q & 32'h10, 32'h10);
    chk("baud_err", q & 32'h20, 32'h20);
    chk("irq_err_link", {31'h0, irq_err}, 32'h1);
    end_of_test();
  end
endmodule : tb_sync_serial_channel
`default_nettype wire
